// file: shared/fle_cfg.svh
/*
  Constants of the float and logic execute unit: word fields,
  exponent limits, fraction width and sequencing counts.
  Assumes inclusion by the unit's package users and design files.
*/
`ifndef FLE_CFG_SVH
`define FLE_CFG_SVH

// Floating word fields (bit 0 of the word is [31] here)
`define FLE_SIGN_BIT   31
`define FLE_EXP_HI     30
`define FLE_EXP_LO     24
`define FLE_FRAC_W     24
// Excess-64 bias and largest biased exponent
`define FLE_EXP_BIAS   9'sh040
`define FLE_EXP_MAX    9'sh07f
// Exponent and fraction all ones
`define FLE_ONES       31'h7fffffff
// Normalized fraction after a rounding carry
`define FLE_FRAC_MSD1  24'h100000
// Number of floating registers
`define FLE_NFREG      8
// Status word bit 5, counted from the most significant end
`define FLE_PSW_FDIV   10
// Divider: dividend scaled by 2**32, 56 steps for a 36-bit quotient
`define FLE_DIV_STEPS  6'h38
`define FLE_ZERO_WORD  32'h00000000

`endif

// file: shared/fle_pkg.sv
/*
  Types of the float and logic execute unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fle_pkg;
  // Operation selected by the decoder
  typedef enum logic [2:0] {
    FLE_OP_NONE = 3'h0,
    FLE_OP_FSUB = 3'h1,
    FLE_OP_FMUL = 3'h2,
    FLE_OP_FDIV = 3'h3,
    FLE_OP_AND  = 3'h4,
    FLE_OP_OR   = 3'h5
  } fle_op_t;
  // Addressing form of the second operand
  typedef enum logic [1:0] {
    FLE_FM_REG = 2'h0,
    FLE_FM_IDX = 2'h1,
    FLE_FM_IMM = 2'h2
  } fle_form_t;
  // Sequencer states, Gray from each to the next in the order listed
  typedef enum logic [2:0] {
    FLE_S_IDLE  = 3'h0,
    FLE_S_FETCH = 3'h1,
    FLE_S_ALIGN = 3'h3,
    FLE_S_CALC  = 3'h2,
    FLE_S_DIVW  = 3'h6,
    FLE_S_NORM  = 3'h7,
    FLE_S_DONE  = 3'h5
  } fle_state_t;
endpackage

// file: src/fle_frac_div.sv
/*
  Bit-serial restoring divider of two 24-bit fractions; the dividend
  is scaled by 2**32 so the quotient carries 36 bits.
  Assumes a normalized nonzero divisor and a one-cycle go pulse.
*/
`timescale 1ns/1ps
`include "fle_cfg.svh"
module fle_frac_div (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Request
  input  wire logic        go,
  input  wire logic [23:0] dividend,
  input  wire logic [23:0] divisor,
  // Answer
  output logic             busy,
  output logic             done,
  output logic      [35:0] quot
);
  logic [55:0] num_r;   // Dividend bits still to bring down
  logic [23:0] dvs_r;   // Held divisor
  logic [24:0] rem_r;   // Partial remainder
  logic [35:0] q_r;     // Quotient shift register
  logic [5:0]  cnt_r;   // Steps left
  logic        busy_r;  // Division running
  logic        done_r;  // Last step pulse
  logic [24:0] rem_sh;  // Remainder with next bit brought down
  logic        fits;    // Divisor goes into it

  // Trial subtraction of one step
  always_comb begin
    rem_sh = {rem_r[23:0], num_r[55]};
    fits   = rem_sh >= {1'b0, dvs_r};
  end

  // One quotient bit per clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      num_r  <= 56'h0;
      dvs_r  <= 24'h0;
      rem_r  <= 25'h0;
      q_r    <= 36'h0;
      cnt_r  <= 6'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (go) begin
        num_r  <= {dividend, 32'h0};
        dvs_r  <= divisor;
        rem_r  <= 25'h0;
        q_r    <= 36'h0;
        cnt_r  <= `FLE_DIV_STEPS;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        num_r <= {num_r[54:0], 1'b0};
        rem_r <= fits ? rem_sh - {1'b0, dvs_r} : rem_sh;
        q_r   <= {q_r[34:0], fits};
        cnt_r <= cnt_r - 6'h1;
        if (cnt_r == 6'h1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign quot = q_r;
endmodule

// file: src/fle_exec.sv
/*
  Execute datapath for hexadecimal floating subtract, multiply and
  divide on eight float registers, and 16-bit AND / OR halfword.
  Assumes the decoder pulses start only while busy is low, and that
  memory answers a read request with one mem_rd_valid pulse.
*/
`timescale 1ns/1ps
`include "fle_cfg.svh"
module fle_exec (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Command from the decoder
  input  wire logic              start,
  input  wire fle_pkg::fle_op_t  op,
  input  wire fle_pkg::fle_form_t form,
  input  wire logic [3:0]        r1_idx,
  input  wire logic [3:0]        r2_idx,
  input  wire logic [15:0]       x2_val,
  input  wire logic [15:0]       addr_field,
  input  wire logic [15:0]       program_status_word,
  output logic                   busy,
  output logic                   done,
  // General register file
  input  wire logic [15:0]       gr1_val,
  input  wire logic [15:0]       gr2_val,
  output logic                   gr_wr_en,
  output logic [3:0]             gr_wr_idx,
  output logic [15:0]            gr_wr_data,
  // Memory read
  output logic                   mem_rd_req,
  output logic [15:0]            mem_addr,
  input  wire logic              mem_rd_valid,
  input  wire logic [31:0]       mem_rd_data,
  // Float register load and read
  input  wire logic              fr_ld_en,
  input  wire logic [2:0]        fr_ld_idx,
  input  wire logic [31:0]       fr_ld_data,
  input  wire logic [2:0]        fr_rd_idx,
  output logic [31:0]            fr_rd_data,
  // Status
  output logic                   ovf_flag,
  output logic                   fdiv_fault_req
);
  import fle_pkg::*;

  fle_state_t      st_r;                   // Sequencer state
  fle_op_t         op_r;                   // Latched operation
  logic [3:0]      r1_r;                   // Destination register
  logic [31:0]     fr_r [`FLE_NFREG];      // Float registers
  logic            sa_r, sb_r, sgn_r;      // Operand and result signs
  logic signed [8:0] ea_r, eb_r, exp_r;    // Exponents, wide for checks
  logic [23:0]     fa_r, fb_r;             // Fractions
  logic [27:0]     acc_r;                  // Fraction plus guard digit
  logic [31:0]     res_r;                  // Float result to write
  logic            wr_r;                   // Float write pulse
  logic            ovf_r, fault_r, done_r; // Status outputs
  logic [15:0]     lg_a_r, lg_b_r, gr_d_r; // Logical operands, result
  logic            gr_we_r, mem_req_r;     // Write and fetch pulses
  logic [15:0]     mem_addr_r;             // Operand address
  logic [31:0]     fr_rd_r;                // Read port
  logic            div_go_r;               // Divider start
  logic            div_done;               // Divider finished
  logic [35:0]     div_q;                  // Divider quotient
  fle_op_t         cur_op;                 // Operation in flight
  logic [15:0]     imm_sum, lg_a;          // Address sum, first halfword
  logic [31:0]     opb, opa;               // Second, first operand word
  logic            take_b;                 // Second operand present
  logic            eff_add, rs;            // Magnitude add, result sign
  logic [24:0]     mag;                    // Aligned magnitude result
  logic [47:0]     prod;                   // Fraction product
  logic signed [8:0] emul, ediv;           // Combined exponents
  logic [24:0]     rnd;                    // Rounded fraction

  // Operand selection and arithmetic terms
  always_comb begin
    cur_op  = (st_r == FLE_S_IDLE) ? op : op_r;
    imm_sum = addr_field + x2_val;
    lg_a    = (st_r == FLE_S_IDLE) ? gr1_val : lg_a_r;
    opa     = fr_r[r1_idx[2:0]];
    take_b  = (st_r == FLE_S_IDLE && start && form != FLE_FM_IDX) ||
              (st_r == FLE_S_FETCH && mem_rd_valid);
    // Source of the second operand
    if (st_r == FLE_S_FETCH)
      opb = mem_rd_data;
    else if (form == FLE_FM_IMM)
      opb = {16'h0, imm_sum};
    else if (op == FLE_OP_AND || op == FLE_OP_OR)
      opb = {16'h0, gr2_val};
    else
      opb = fr_r[r2_idx[2:0]];
    // Subtract is an add when the signs differ
    eff_add = sa_r != sb_r;
    if (eff_add)
      mag = {1'b0, fa_r} + {1'b0, fb_r};
    else if (fa_r >= fb_r)
      mag = {1'b0, fa_r - fb_r};
    else
      mag = {1'b0, fb_r - fa_r};
    rs   = (eff_add || fa_r >= fb_r) ? sa_r : ~sa_r;
    prod = fa_r * fb_r;
    emul = ea_r + eb_r - `FLE_EXP_BIAS;
    ediv = ea_r - eb_r + `FLE_EXP_BIAS;
    rnd  = {1'b0, acc_r[27:4]} + {24'h0, acc_r[3]};
  end

  // Hand a float result to the write stage
  task automatic fin(input logic [31:0] v, input logic ov);
    res_r <= v;
    ovf_r <= ov;
    wr_r  <= 1'b1;
    st_r  <= FLE_S_DONE;
  endtask

  // Instruction sequencer and float datapath
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= FLE_S_IDLE;
      op_r <= FLE_OP_NONE;
      r1_r <= 4'h0;
      {sa_r, sb_r, sgn_r} <= 3'h0;
      {ea_r, eb_r, exp_r} <= 27'h0;
      {fa_r, fb_r} <= 48'h0;
      acc_r <= 28'h0;
      res_r <= 32'h0;
      {wr_r, ovf_r, fault_r, done_r} <= 4'h0;
      {lg_a_r, lg_b_r, gr_d_r} <= 48'h0;
      {gr_we_r, mem_req_r, div_go_r} <= 3'h0;
      mem_addr_r <= 16'h0;
    end else begin
      {wr_r, fault_r, done_r, gr_we_r, mem_req_r, div_go_r} <= 6'h0;
      // Latch the second operand when it is present
      if (take_b) begin
        sb_r   <= opb[`FLE_SIGN_BIT];
        eb_r   <= {2'b00, opb[`FLE_EXP_HI:`FLE_EXP_LO]};
        fb_r   <= opb[`FLE_FRAC_W-1:0];
        lg_b_r <= opb[15:0];
        if (cur_op == FLE_OP_AND || cur_op == FLE_OP_OR) begin
          gr_d_r  <= (cur_op == FLE_OP_AND) ? (lg_a & opb[15:0])
                                            : (lg_a | opb[15:0]);
          gr_we_r <= 1'b1;
          st_r    <= FLE_S_DONE;
        end else if (cur_op == FLE_OP_FSUB)
          st_r <= FLE_S_ALIGN;
        else if (cur_op == FLE_OP_NONE)
          st_r <= FLE_S_DONE;
        else
          st_r <= FLE_S_CALC;
      end
      case (st_r)
        // Accept a command, read first operand
        FLE_S_IDLE: begin
          if (start) begin
            op_r       <= op;
            r1_r       <= r1_idx;
            lg_a_r     <= gr1_val;
            sa_r       <= opa[`FLE_SIGN_BIT];
            ea_r       <= {2'b00, opa[`FLE_EXP_HI:`FLE_EXP_LO]};
            fa_r       <= opa[`FLE_FRAC_W-1:0];
            mem_addr_r <= imm_sum;
            if (form == FLE_FM_IDX) begin
              mem_req_r <= 1'b1;
              st_r      <= FLE_S_FETCH;
            end
          end
        end
        // Waiting for memory; handled by take_b
        FLE_S_FETCH: begin
        end
        // Hex alignment, one digit per clock
        FLE_S_ALIGN: begin
          if (ea_r < eb_r) begin
            fa_r <= fa_r >> 4;
            ea_r <= ea_r + 9'sh001;
          end else if (eb_r < ea_r) begin
            fb_r <= fb_r >> 4;
            eb_r <= eb_r + 9'sh001;
          end else
            st_r <= FLE_S_CALC;
        end
        // Combine fractions and exponents
        FLE_S_CALC: begin
          sgn_r <= sa_r ^ sb_r;
          case (op_r)
            FLE_OP_FSUB: begin
              exp_r <= ea_r;
              sgn_r <= rs;
              if (mag == 25'h0)
                fin(`FLE_ZERO_WORD, 1'b0);
              else if (mag[24] && ea_r == `FLE_EXP_MAX)
                fin({rs, `FLE_ONES}, 1'b1);
              else if (mag[24])
                fin({rs, 7'(ea_r + 9'sh001), 3'h0, mag[24:4]}, 1'b0);
              else begin
                acc_r <= {mag[23:0], 4'h0};
                st_r  <= FLE_S_NORM;
              end
            end
            FLE_OP_FMUL: begin
              exp_r <= emul;
              if (emul > `FLE_EXP_MAX)
                fin({sa_r ^ sb_r, `FLE_ONES}, 1'b1);
              else if (emul < 9'sh000)
                fin(`FLE_ZERO_WORD, 1'b1);
              else if (prod == 48'h0)
                fin(`FLE_ZERO_WORD, 1'b0);
              else begin
                acc_r <= prod[47:20];
                st_r  <= FLE_S_NORM;
              end
            end
            FLE_OP_FDIV: begin
              exp_r <= ediv;
              if (fb_r == 24'h0) begin
                // Operands stay as they were, no write
                fault_r <= program_status_word[`FLE_PSW_FDIV];
                st_r    <= FLE_S_DONE;
              end else if (ediv > `FLE_EXP_MAX)
                fin({sa_r ^ sb_r, `FLE_ONES}, 1'b1);
              else if (ediv < 9'sh000)
                fin(`FLE_ZERO_WORD, 1'b1);
              else if (fa_r == 24'h0)
                fin(`FLE_ZERO_WORD, 1'b0);
              else begin
                div_go_r <= 1'b1;
                st_r     <= FLE_S_DIVW;
              end
            end
            default: st_r <= FLE_S_DONE;
          endcase
        end
        // Quotient of one or more takes a digit and an exponent step
        FLE_S_DIVW: begin
          if (div_done) begin
            if (div_q[35:32] != 4'h0 && exp_r == `FLE_EXP_MAX)
              fin({sgn_r, `FLE_ONES}, 1'b1);
            else if (div_q[35:32] != 4'h0) begin
              acc_r <= div_q[35:8];
              exp_r <= exp_r + 9'sh001;
              st_r  <= FLE_S_NORM;
            end else begin
              acc_r <= div_q[31:4];
              st_r  <= FLE_S_NORM;
            end
          end
        end
        // Hex normalization, then rounding to 24 bits
        FLE_S_NORM: begin
          if (acc_r[27:24] == 4'h0 && exp_r == 9'sh000)
            fin(`FLE_ZERO_WORD, 1'b1);
          else if (acc_r[27:24] == 4'h0) begin
            acc_r <= {acc_r[23:0], 4'h0};
            exp_r <= exp_r - 9'sh001;
          end else if (rnd[24] && exp_r == `FLE_EXP_MAX)
            fin({sgn_r, `FLE_ONES}, 1'b1);
          else if (rnd[24])
            fin({sgn_r, 7'(exp_r + 9'sh001), `FLE_FRAC_MSD1}, 1'b0);
          else
            fin({sgn_r, exp_r[6:0], rnd[23:0]}, 1'b0);
        end
        // Result is written this cycle
        FLE_S_DONE: begin
          done_r <= 1'b1;
          st_r   <= FLE_S_IDLE;
        end
        default: st_r <= FLE_S_IDLE;
      endcase
    end
  end

  // Float register file; results go only to the first operand, loads to any register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `FLE_NFREG; i++)
        fr_r[i] <= 32'h0;
      fr_rd_r <= 32'h0;
    end else begin
      if (wr_r)
        fr_r[r1_r[2:0]] <= res_r;
      else if (fr_ld_en)
        fr_r[fr_ld_idx] <= fr_ld_data;
      fr_rd_r <= fr_r[fr_rd_idx];
    end
  end

  // Fraction divider
  fle_frac_div u_div (
    .clock    (clock),
    .rst_n    (rst_n),
    .go       (div_go_r),
    .dividend (fa_r),
    .divisor  (fb_r),
    .busy     (),
    .done     (div_done),
    .quot     (div_q)
  );

  // Outputs
  assign busy           = st_r != FLE_S_IDLE;
  assign done           = done_r;
  assign gr_wr_en       = gr_we_r;
  assign gr_wr_idx      = r1_r;
  assign gr_wr_data     = gr_d_r;
  assign mem_rd_req     = mem_req_r;
  assign mem_addr       = mem_addr_r;
  assign fr_rd_data     = fr_rd_r;
  assign ovf_flag       = ovf_r;
  assign fdiv_fault_req = fault_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_quiet2;
    !wr_r [*2];
  endsequence
  property p_align;
    st_r == FLE_S_ALIGN && ea_r < eb_r |=>
      fa_r == ($past(fa_r) >> 4) && ea_r == $past(ea_r) + 9'sh001;
  endproperty
  a_align: assert property (p_align) else $error("align step wrong");
  property p_carry;
    st_r == FLE_S_CALC && op_r == FLE_OP_FSUB && mag[24] && ea_r < `FLE_EXP_MAX |=>
      wr_r && res_r[23:20] == 4'h1 && res_r[30:24] == $past(ea_r[6:0]) + 7'h1;
  endproperty
  a_carry: assert property (p_carry) else $error("carry digit wrong");
  property p_sub_ovf;
    st_r == FLE_S_CALC && op_r == FLE_OP_FSUB && mag[24] && ea_r == `FLE_EXP_MAX |=>
      ovf_r && res_r[30:0] == `FLE_ONES && res_r[31] == $past(rs);
  endproperty
  a_sub_ovf: assert property (p_sub_ovf) else $error("overflow word wrong");
  property p_norm;
    st_r == FLE_S_NORM && acc_r[27:24] == 4'h0 && exp_r != 9'sh000 |=>
      acc_r == ($past(acc_r) << 4) && exp_r == $past(exp_r) - 9'sh001;
  endproperty
  a_norm: assert property (p_norm) else $error("normalize step wrong");
  property p_unf;
    st_r == FLE_S_NORM && acc_r[27:24] == 4'h0 && exp_r == 9'sh000 |=>
      wr_r && res_r == 32'h0 && ovf_r ##1 done_r;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not zeroed");
  property p_mul_exp;
    st_r == FLE_S_CALC && op_r == FLE_OP_FMUL |=>
      exp_r == $past(ea_r) + $past(eb_r) - `FLE_EXP_BIAS;
  endproperty
  a_mul_exp: assert property (p_mul_exp) else $error("product exponent wrong");
  property p_sign;
    st_r == FLE_S_CALC && (op_r == FLE_OP_FMUL || op_r == FLE_OP_FDIV) |=>
      sgn_r == ($past(sa_r) ^ $past(sb_r));
  endproperty
  a_sign: assert property (p_sign) else $error("sign rule broken");
  property p_fault;
    st_r == FLE_S_CALC && op_r == FLE_OP_FDIV && fb_r == 24'h0 |=>
      fault_r == $past(program_status_word[`FLE_PSW_FDIV]) and s_quiet2;
  endproperty
  a_fault: assert property (p_fault) else $error("zero divisor mishandled");
  property p_and;
    gr_we_r && op_r == FLE_OP_AND |-> gr_d_r == (lg_a_r & lg_b_r);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_or;
    gr_we_r && op_r == FLE_OP_OR |-> gr_d_r == (lg_a_r | lg_b_r);
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  property p_imm;
    st_r == FLE_S_IDLE && start && form == FLE_FM_IMM |=>
      lg_b_r == $past(imm_sum) && !mem_req_r;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");
endmodule

// file: bench/fle_mem_model.sv
/*
  Memory model on the far side of the unit's read port.
  Assumes one read request pulse per fetch and a shared clock.
*/
`timescale 1ns/1ps
module fle_mem_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Answer pace
  input  wire logic        slow,
  // Read port
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_rd_valid,
  output logic      [31:0] mem_rd_data
);
  logic [3:0] wait_r;  // Cycles before the answer, 0 when idle
  // Answer after one or five cycles with the address in both halves;
  // between answers the data toggles so stale data is never trusted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r       <= 4'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 32'h0;
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd_req) begin
        wait_r <= slow ? 4'h5 : 4'h1;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
        if (wait_r == 4'h1) begin
          mem_rd_valid <= 1'b1;
          mem_rd_data  <= {mem_addr, mem_addr};
        end
      end
    end
  end
endmodule

// file: bench/float_and_logic_execute_tb.sv
/*
  Self-checking bench of the float and logic execute unit.
  Assumes the memory model returns the read address in both halves.
*/
`timescale 1ns/1ps
module float_and_logic_execute_tb;
  import fle_pkg::*;
  logic        clock = 0, rst_n = 0, start = 0, slow = 0, fr_ld_en = 0;
  logic        busy, done, gr_wr_en, mem_rd_req, mem_rd_valid, ovf_flag, fdiv_fault_req;
  fle_op_t     op = FLE_OP_NONE;
  fle_form_t   form = FLE_FM_REG;
  logic [3:0]  r1_idx = 0, r2_idx = 0, gr_wr_idx, wr_idx;
  logic [15:0] x2_val = 0, addr_field = 0, program_status_word = 0, gr1_val = 0;
  logic [15:0] gr2_val = 0, gr_wr_data, mem_addr, wr_val;
  logic [2:0]  fr_ld_idx = 0, fr_rd_idx = 0;
  logic [31:0] fr_ld_data = 0, fr_rd_data, mem_rd_data;
  logic        wr_seen, flt_seen, bsy;
  int          miscompares = 0, n_tests = 0, n_wait, n_req, cyc = 0;
  // Float cases: op, first, second, expected result, expected flag
  logic [98:0] tbl [13] = '{
    {2'h1, 32'h41310000, 32'h41300000, 32'h40100000, 1'b0},
    {2'h1, 32'h42100000, 32'h41100000, 32'h41f00000, 1'b0},
    {2'h1, 32'h41100000, 32'hc1f00000, 32'h42100000, 1'b0},
    {2'h1, 32'h7ff00000, 32'hfff00000, 32'h7fffffff, 1'b1},
    {2'h1, 32'h00120000, 32'h00110000, 32'h00000000, 1'b1},
    {2'h2, 32'hc1100000, 32'h41200000, 32'hc1200000, 1'b0},
    {2'h2, 32'h7f100000, 32'h7f100000, 32'h7fffffff, 1'b1},
    {2'h2, 32'h01100000, 32'h01100000, 32'h00000000, 1'b1},
    {2'h2, 32'h41100000, 32'h00000000, 32'h00000000, 1'b0},
    {2'h2, 32'h20100000, 32'h20100000, 32'h00000000, 1'b1},
    {2'h3, 32'hc1300000, 32'h41200000, 32'hc1180000, 1'b0},
    {2'h3, 32'h41200000, 32'h41300000, 32'h40aaaaab, 1'b0},
    {2'h3, 32'h7f100000, 32'h01100000, 32'h7fffffff, 1'b1}
  };

  fle_exec u_dut (.clock, .rst_n, .start, .op, .form, .r1_idx, .r2_idx, .x2_val,
    .addr_field, .program_status_word, .busy, .done, .gr1_val, .gr2_val, .gr_wr_en,
    .gr_wr_idx, .gr_wr_data, .mem_rd_req, .mem_addr, .mem_rd_valid, .mem_rd_data,
    .fr_ld_en, .fr_ld_idx, .fr_ld_data, .fr_rd_idx, .fr_rd_data, .ovf_flag,
    .fdiv_fault_req);
  fle_mem_model u_mem (.clock, .rst_n, .slow, .mem_rd_req, .mem_addr, .mem_rd_valid,
    .mem_rd_data);

  // Clock of 50 ns
  initial begin
    forever #25 clock = ~clock;
  end
  // Cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Compare a seen value against the expected one
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s: %h expected %h", $time, m, seen, exp);
    end
  endtask
  // Expected halfword result; immediate and indexed use address plus index
  function automatic logic [15:0] lexp(fle_op_t o, fle_form_t f,
                                       logic [15:0] g1, g2, a, x);
    logic [15:0] s;
    s = (f == FLE_FM_REG) ? g2 : a + x;
    return (o == FLE_OP_AND) ? (g1 & s) : (g1 | s);
  endfunction
  // Issue one command and watch its outputs until done
  task automatic cmd(input fle_op_t o, input fle_form_t f, input logic [3:0] a1, b2,
                     input logic [15:0] x, a, g1, g2);
    @(negedge clock);
    {start, op, form, r1_idx, r2_idx} = {1'b1, o, f, a1, b2};
    {x2_val, addr_field, gr1_val, gr2_val} = {x, a, g1, g2};
    @(negedge clock);
    start = 0;
    {wr_seen, flt_seen, n_wait, n_req} = '0;
    bsy = busy;
    while (done !== 1'b1) begin
      if (mem_rd_req === 1'b1) n_req++;
      if (gr_wr_en === 1'b1) {wr_seen, wr_val, wr_idx} = {1'b1, gr_wr_data, gr_wr_idx};
      if (fdiv_fault_req === 1'b1) flt_seen = 1;
      @(negedge clock);
      n_wait++;
      if (n_wait > 300) begin
        miscompares++;
        stop_test();
      end
    end
  endtask
  // Load a float register
  task automatic fld(input logic [2:0] i, input logic [31:0] d);
    @(negedge clock);
    {fr_ld_en, fr_ld_idx, fr_ld_data} = {1'b1, i, d};
    @(negedge clock);
    fr_ld_en = 0;
  endtask
  // Read a float register
  task automatic frd(input logic [2:0] i, output logic [31:0] d);
    fr_rd_idx = i;
    repeat (2) @(negedge clock);
    d = fr_rd_data;
  endtask

  // Main sequence
  initial begin
    logic [15:0] x, a, g1, g2;
    logic [31:0] d, r;
    logic [2:0]  p1, p2;
    fle_op_t     o;
    fle_form_t   f;
    logic        ov;
    r = $urandom(32'h4a38d211);
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1;
    // Halfword logic in all forms, paces and random data
    for (int i = 0; i < 24; i++) begin
      o = i[0] ? FLE_OP_AND : FLE_OP_OR;
      f = fle_form_t'(i % 3);
      slow = i[1];
      {x, a, g1, g2} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
      if (i < 3) {x, a, g1} = {16'h0001, 16'hffff, 16'hffff};
      r = $urandom;
      cmd(o, f, r[3:0], r[7:4], x, a, g1, g2);
      chk(wr_seen, 1'b1, "write pulse");
      chk(wr_val, lexp(o, f, g1, g2, a, x), "logic result");
      chk(wr_idx, r[3:0], "write index");
      chk(bsy, 1'b1, "busy after start");
      chk(n_req, f == FLE_FM_IDX, "fetch count");
      if (f == FLE_FM_IDX) chk(mem_addr, 16'(a + x), "fetch address");
      else chk(n_wait, 1, "done latency");
      $display("logic test %0d done", i);
    end
    // Float table
    for (int i = 0; i < 13; i++) begin
      {p1, p2} = {3'(i), 3'(i + 3)};
      fld(p1, tbl[i][96:65]);
      fld(p2, tbl[i][64:33]);
      cmd(fle_op_t'({1'b0, tbl[i][98:97]}), FLE_FM_REG, {1'b0, p1}, {1'b0, p2}, 0, 0, 0, 0);
      frd(p1, d);
      chk(d, tbl[i][32:1], "float result");
      chk(ovf_flag, tbl[i][0], "overflow flag");
      frd(p2, d);
      chk(d, tbl[i][64:33], "second operand");
      $display("float test %0d done", i);
    end
    // Indexed float subtract; memory answers address 4110 with 41104110
    fld(3'h2, 32'h41304110);
    cmd(FLE_OP_FSUB, FLE_FM_IDX, 4'h2, 4'h0, 16'h0010, 16'h4100, 0, 0);
    frd(3'h2, d);
    chk(d, 32'h41200000, "indexed subtract");
    // Zero divisor with the fault enable off and on
    for (int p = 0; p < 2; p++) begin
      fld(3'h5, 32'h41100000);
      fld(3'h6, 32'h0);
      program_status_word = 16'(p) << 10;
      ov = ovf_flag;
      cmd(FLE_OP_FDIV, FLE_FM_REG, 4'h5, 4'h6, 0, 0, 0, 0);
      chk(flt_seen, p[0], "fault request");
      frd(3'h5, d);
      chk(d, 32'h41100000, "dividend kept");
      chk(ovf_flag, ov, "flag kept");
      $display("zero divisor test %0d done", p);
    end
    stop_test();
  end
endmodule
